// [verilog/isc_store_ctrl_ops.sv]
// Execution unit for indirect store, option load, software reset, return from interrupt, no-op.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Indirect store writes working register to address from pointer chosen by index.
// - Two-bit mode picks pre-increment, pre-decrement, post-increment, post-decrement.
// - Pre modes store at pointer plus or minus one, computed before writing.
// - Relative mode stores at pointer plus signed offset; pointer stays unchanged.
// - Afterwards pointer is old plus one, old minus one, or unchanged.
// - Pointer arithmetic is sixteen bit and wraps at both ends.
// - Indirect store and pointer stepping change no status flag.
// - Indirect window has no storage; accesses not met by a store or software reset in the same cycle go to the pointer's address.
// - Option load copies working register into option register, flags untouched.
// - Software reset requests device reset, reloads pointers, option and interrupt control, and clears the reset-instruction flag.
// - Return from interrupt pops stack into program counter over two cycles.
// - Return from interrupt also sets global interrupt enable, bit seven.
module isc_store_ctrl_ops (
  input wire logic clk,
  input wire logic rst,
  input wire isc_pkg::isc_instr_t instr,
  output logic instrReady,
  input wire logic [7:0] workReg,
  input wire logic [14:0] stackTop,
  input wire isc_pkg::isc_file_acc_t fileAcc,
  output isc_pkg::isc_mem_req_t memReq,
  output logic stackPop,
  output logic pcLoad,
  output logic [14:0] pcValue,
  output logic deviceResetReq,
  output logic [7:0] optionCfg,
  output logic [7:0] irqControl,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData
);

  typedef enum logic {ST_READY, ST_RET_SECOND} isc_state_t;

  isc_state_t state;
  isc_state_t next_state;
  logic [15:0] filePtr [isc_pkg::NUM_PTR];
  logic [15:0] effAddr [isc_pkg::NUM_PTR];
  logic [15:0] nextPtr [isc_pkg::NUM_PTR];
  logic [7:0] powerControl;
  logic [7:0] next_irqControl;
  logic take;
  logic storeTake;
  logic swResetTake;
  logic retTake;
  logic optionTake;
  logic relMode;
  logic winHit;
  logic winSel;
  logic [15:0] storeAddr;
  logic [15:0] winAddr;
  logic [isc_pkg::NUM_PTR-1:0] ptrLoWr;
  logic [isc_pkg::NUM_PTR-1:0] ptrHiWr;
  logic optionWr;
  logic irqCtrlWr;
  logic powerCtrlWr;
  logic [7:0] rdMux;

  assign take = instr.valid && instrReady;
  assign relMode = instr.op == isc_pkg::ISC_OP_STORE_REL;

  // Decode of a taken instruction; the two unused op codes fall through as no-ops.
  always_comb begin
    storeTake = 1'b0;
    swResetTake = 1'b0;
    retTake = 1'b0;
    optionTake = 1'b0;
    if (take) begin
      unique case (instr.op)
        isc_pkg::ISC_OP_NOP: begin
          // A no-op raises no strobe, so no register, pointer or request moves.
          storeTake = 1'b0;
        end
        isc_pkg::ISC_OP_STORE_IND: begin
          storeTake = 1'b1;
        end
        isc_pkg::ISC_OP_STORE_REL: begin
          storeTake = 1'b1;
        end
        isc_pkg::ISC_OP_OPTION: begin
          optionTake = 1'b1;
        end
        isc_pkg::ISC_OP_SWRESET: begin
          swResetTake = 1'b1;
        end
        isc_pkg::ISC_OP_RETIRQ: begin
          retTake = 1'b1;
        end
        default: begin
          storeTake = 1'b0;
        end
      endcase
    end
  end

  // Software write decode; an unmapped offset selects nothing, so the write is lost.
  always_comb begin
    ptrLoWr = '0;
    ptrHiWr = '0;
    optionWr = 1'b0;
    irqCtrlWr = 1'b0;
    powerCtrlWr = 1'b0;
    if (regWrite) begin
      unique case (regAddr)
        isc_pkg::REG_FP0_LO: begin
          ptrLoWr[0] = 1'b1;
        end
        isc_pkg::REG_FP0_HI: begin
          ptrHiWr[0] = 1'b1;
        end
        isc_pkg::REG_FP1_LO: begin
          ptrLoWr[1] = 1'b1;
        end
        isc_pkg::REG_FP1_HI: begin
          ptrHiWr[1] = 1'b1;
        end
        isc_pkg::REG_OPTION: begin
          optionWr = 1'b1;
        end
        isc_pkg::REG_IRQ_CTRL: begin
          irqCtrlWr = 1'b1;
        end
        isc_pkg::REG_POWER_CTRL: begin
          powerCtrlWr = 1'b1;
        end
        default: begin
          optionWr = 1'b0;
        end
      endcase
    end
  end

  assign winHit = fileAcc.valid &&
                  (fileAcc.addr == isc_pkg::WIN0_ADDR || fileAcc.addr == isc_pkg::WIN1_ADDR);
  assign winSel = fileAcc.addr == isc_pkg::WIN1_ADDR;

  // Store and window addresses, each taken from the pointer that its index names.
  always_comb begin
    storeAddr = effAddr[0];
    winAddr = filePtr[0];
    if (instr.ptrSel) begin
      storeAddr = effAddr[1];
    end
    if (winSel) begin
      winAddr = filePtr[1];
    end
  end

  // Sequencing: only the return occupies a second cycle; everything else is single cycle.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_READY: begin
        if (retTake) begin
          next_state = ST_RET_SECOND;
        end
      end
      ST_RET_SECOND: begin
        next_state = ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_READY;
      instrReady <= 1'b1;
    end else begin
      state <= next_state;
      instrReady <= next_state == ST_READY;
    end
  end

  // Pop and counter load are issued in the second cycle of the return.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stackPop <= 1'b0;
      pcLoad <= 1'b0;
    end else begin
      stackPop <= retTake;
      pcLoad <= retTake;
    end
  end

  // The counter value is held after the load so the fetch side may sample it late.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcValue <= 15'h0000;
    end else if (retTake) begin
      pcValue <= stackTop;
    end
  end

  // Pointers, each with its own step unit and byte-wise register access.
  for (genvar i = 0; i < isc_pkg::NUM_PTR; i++) begin : gPtr
    isc_ptr_step uStep (
      .ptr(filePtr[i]),
      .mode(instr.mode),
      .relative(relMode),
      .offset(instr.offset),
      .effAddr(effAddr[i]),
      .nextPtr(nextPtr[i])
    );

    // An instruction update wins over a software write to the same pointer.
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        filePtr[i] <= isc_pkg::FP_RESET;
      end else if (swResetTake) begin
        filePtr[i] <= isc_pkg::FP_RESET;
      end else if (storeTake && instr.ptrSel == 1'(i)) begin
        filePtr[i] <= nextPtr[i];
      end else if (ptrLoWr[i]) begin
        filePtr[i][7:0] <= regWrData;
      end else if (ptrHiWr[i]) begin
        filePtr[i][15:8] <= regWrData;
      end
    end
  end

  // Data memory requests: indirect stores and window accesses redirected through a pointer.
  // This unit has no status flag output at all, so stores and steps cannot disturb flags.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memReq <= '0;
    end else begin
      memReq.valid <= 1'b0;
      if (storeTake) begin
        memReq.valid <= 1'b1;
        memReq.write <= 1'b1;
        memReq.addr <= storeAddr;
        memReq.data <= workReg;
      end else if (winHit && !swResetTake) begin
        memReq.valid <= 1'b1;
        memReq.write <= fileAcc.write;
        memReq.addr <= winAddr;
        memReq.data <= fileAcc.data;
      end
    end
  end

  // Option configuration register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      optionCfg <= isc_pkg::OPTION_RESET;
    end else if (swResetTake) begin
      optionCfg <= isc_pkg::OPTION_RESET;
    end else if (optionTake) begin
      optionCfg <= workReg;
    end else if (optionWr) begin
      optionCfg <= regWrData;
    end
  end

  // Interrupt control: the return's set of the global enable wins over a software write.
  always_comb begin
    next_irqControl = irqControl;
    if (irqCtrlWr) begin
      next_irqControl = regWrData;
    end
    if (retTake) begin
      next_irqControl[isc_pkg::GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
    end
    if (swResetTake) begin
      next_irqControl = isc_pkg::IRQ_CTRL_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqControl <= isc_pkg::IRQ_CTRL_RESET;
    end else begin
      irqControl <= next_irqControl;
    end
  end

  // Power control: the register survives the software reset, except the reset-instruction flag, cleared by it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerControl <= isc_pkg::POWER_CTRL_RESET;
    end else if (swResetTake) begin
      powerControl[isc_pkg::RESET_INSTR_FLAG_BIT] <= 1'b0;
    end else if (powerCtrlWr) begin
      powerControl <= regWrData & isc_pkg::POWER_CTRL_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deviceResetReq <= 1'b0;
    end else begin
      deviceResetReq <= swResetTake;
    end
  end

  // Read selection; unmapped offsets read as zero.
  always_comb begin
    rdMux = 8'h00;
    unique case (regAddr)
      isc_pkg::REG_FP0_LO: begin
        rdMux = filePtr[0][7:0];
      end
      isc_pkg::REG_FP0_HI: begin
        rdMux = filePtr[0][15:8];
      end
      isc_pkg::REG_FP1_LO: begin
        rdMux = filePtr[1][7:0];
      end
      isc_pkg::REG_FP1_HI: begin
        rdMux = filePtr[1][15:8];
      end
      isc_pkg::REG_OPTION: begin
        rdMux = optionCfg;
      end
      isc_pkg::REG_IRQ_CTRL: begin
        rdMux = irqControl;
      end
      isc_pkg::REG_POWER_CTRL: begin
        rdMux = powerControl;
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [verilog/isc_pkg.sv]
// Shared types and constants for the indirect store and control operation unit.
package isc_pkg;

  typedef enum logic [2:0] {
    ISC_OP_NOP,
    ISC_OP_STORE_IND,
    ISC_OP_STORE_REL,
    ISC_OP_OPTION,
    ISC_OP_SWRESET,
    ISC_OP_RETIRQ
  } isc_op_t;

  typedef struct packed {
    logic valid;
    isc_op_t op;
    logic ptrSel;
    logic [1:0] mode;
    logic [5:0] offset;
  } isc_instr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } isc_file_acc_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } isc_mem_req_t;

  localparam int NUM_PTR = 2;

  // Indirect mode field encodings.
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  localparam logic [15:0] PTR_STEP = 16'h0001;

  // Register port offsets.
  localparam logic [3:0] REG_FP0_LO = 4'h0;
  localparam logic [3:0] REG_FP0_HI = 4'h1;
  localparam logic [3:0] REG_FP1_LO = 4'h2;
  localparam logic [3:0] REG_FP1_HI = 4'h3;
  localparam logic [3:0] REG_OPTION = 4'h4;
  localparam logic [3:0] REG_IRQ_CTRL = 4'h5;
  localparam logic [3:0] REG_POWER_CTRL = 4'h6;

  // Reset values and field positions.
  localparam logic [15:0] FP_RESET = 16'h0000;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int RESET_INSTR_FLAG_BIT = 2;
  localparam logic [7:0] POWER_CTRL_MASK = 8'h04;
  localparam logic [7:0] POWER_CTRL_RESET = 8'h04;

  // File addresses of the two indirect window registers.
  localparam logic [6:0] WIN0_ADDR = 7'h00;
  localparam logic [6:0] WIN1_ADDR = 7'h01;

endpackage

// [verilog/isc_ptr_step.sv]
// Effective address and updated value of one file pointer for an indirect store.
`timescale 1ns/10ps
`default_nettype none

module isc_ptr_step (
  input wire logic [15:0] ptr,
  input wire logic [1:0] mode,
  input wire logic relative,
  input wire logic [5:0] offset,
  output logic [15:0] effAddr,
  output logic [15:0] nextPtr
);

  logic [15:0] plusOne;
  logic [15:0] minusOne;
  logic [15:0] relAddr;

  // Sixteen-bit sums wrap at both ends of the range.
  assign plusOne = ptr + isc_pkg::PTR_STEP;
  assign minusOne = ptr - isc_pkg::PTR_STEP;
  assign relAddr = ptr + {{10{offset[5]}}, offset};

  always_comb begin
    effAddr = ptr;
    nextPtr = ptr;
    if (relative) begin
      effAddr = relAddr;
      nextPtr = ptr;
    end else begin
      unique case (mode)
        isc_pkg::MODE_PRE_INC: begin
          effAddr = plusOne;
          nextPtr = plusOne;
        end
        isc_pkg::MODE_PRE_DEC: begin
          effAddr = minusOne;
          nextPtr = minusOne;
        end
        isc_pkg::MODE_POST_INC: begin
          effAddr = ptr;
          nextPtr = plusOne;
        end
        isc_pkg::MODE_POST_DEC: begin
          effAddr = ptr;
          nextPtr = minusOne;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [tb/isc_store_ctrl_ops_sva.sv]
// Assertions on the ports of the indirect store and control unit.
`timescale 1ns/10ps
`default_nettype none
module isc_store_ctrl_ops_sva (
  input wire logic clk,
  input wire logic rst,
  input wire isc_pkg::isc_instr_t instr,
  input wire logic instrReady,
  input wire logic [7:0] workReg,
  input wire logic [14:0] stackTop,
  input wire isc_pkg::isc_file_acc_t fileAcc,
  input wire isc_pkg::isc_mem_req_t memReq,
  input wire logic stackPop,
  input wire logic pcLoad,
  input wire logic [14:0] pcValue,
  input wire logic deviceResetReq,
  input wire logic [7:0] optionCfg,
  input wire logic [7:0] irqControl,
  input wire logic regWrite
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic tk = instr.valid && instrReady;
  wire logic tSt = tk && instr.op == isc_pkg::ISC_OP_STORE_IND;
  wire logic tRel = tk && instr.op == isc_pkg::ISC_OP_STORE_REL;
  wire logic tOpt = tk && instr.op == isc_pkg::ISC_OP_OPTION;
  wire logic tSw = tk && instr.op == isc_pkg::ISC_OP_SWRESET;
  wire logic tRet = tk && instr.op == isc_pkg::ISC_OP_RETIRQ;
  wire logic tNop = tk && instr.op == isc_pkg::ISC_OP_NOP;
  a_store_write: assert property (tSt |=> memReq.valid && memReq.write
    && memReq.data == $past(workReg)) else $error("Store request wrong.");
  a_ret_pop: assert property (tRet |=> stackPop && pcLoad && pcValue == $past(stackTop))
    else $error("Return did not load pc.");
  a_ret_two: assert property (tRet |=> !instrReady ##1 instrReady)
    else $error("Return length wrong.");
  a_pop_cause: assert property (stackPop |-> $past(tRet))
    else $error("Pop without return.");
  a_ret_gie: assert property (tRet |=> irqControl[isc_pkg::GLOBAL_IRQ_ENABLE_BIT])
    else $error("Global enable not set.");
  a_opt_load: assert property (tOpt |=> optionCfg == $past(workReg))
    else $error("Option not loaded.");
  a_sw_reset: assert property (tSw |=> deviceResetReq && optionCfg == isc_pkg::OPTION_RESET)
    else $error("Soft reset wrong.");
  a_reset_cause: assert property (deviceResetReq |-> $past(tSw))
    else $error("Reset request without cause.");
  a_nop_still: assert property (tNop && !fileAcc.valid && !regWrite |=> !memReq.valid
    && $stable(optionCfg) && $stable(irqControl)) else $error("No-op changed state.");
  a_win_pass: assert property (fileAcc.valid && fileAcc.addr == isc_pkg::WIN1_ADDR
    && !tSt && !tRel && !tSw |=> memReq.valid && memReq.data == $past(fileAcc.data))
    else $error("Window lost.");
endmodule
bind isc_store_ctrl_ops isc_store_ctrl_ops_sva sva (.*);
`default_nettype wire

// [tb/isc_file_model.sv]
// Data memory and call stack on the far side of the unit.
`timescale 1ns/10ps
`default_nettype none
module isc_file_model (
  input wire logic clk,
  input wire logic rst,
  input wire isc_pkg::isc_mem_req_t memReq,
  input wire logic stackPop,
  output logic [14:0] stackTop
);
  logic [7:0] mem [0:65535];
  logic [14:0] stack [0:3] = '{15'h0123, 15'h7abc, 15'h0001, 15'h0002};
  logic [1:0] sp;
  assign stackTop = stack[sp];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp <= 2'h0;
    end else if (stackPop) begin
      sp <= sp + 2'h1;
    end
  end
  always @(posedge clk) begin
    if (memReq.valid && memReq.write) begin
      mem[memReq.addr] <= memReq.data;
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the indirect store and control unit.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0;
  logic rst = 1;
  logic regWrite = 0;
  logic regRead = 0;
  logic [7:0] workReg = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [3:0] regAddr = 4'h0;
  isc_pkg::isc_instr_t instr = '0;
  isc_pkg::isc_file_acc_t fileAcc = '0;
  isc_pkg::isc_mem_req_t memReq;
  logic instrReady, stackPop, pcLoad, deviceResetReq;
  logic [14:0] stackTop, pcValue;
  logic [7:0] optionCfg, irqControl, regRdData;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] ea, np;
  isc_store_ctrl_ops dut (.*);
  isc_file_model fm (.*);
  initial forever #10 clk = ~clk;
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("register", e, regRdData);
  endtask
  task automatic setp(input logic s, input logic [15:0] v);
    wr({2'h0, s, 1'b0}, v[7:0]);
    wr({2'h0, s, 1'b1}, v[15:8]);
  endtask
  task automatic rdp(input logic s, input logic [15:0] e);
    rd({2'h0, s, 1'b0}, e[7:0]);
    rd({2'h0, s, 1'b1}, e[15:8]);
  endtask
  task automatic ex(input isc_pkg::isc_op_t op, input logic s, input logic [1:0] m,
                    input logic [5:0] off, input logic [7:0] w);
    @(posedge clk);
    workReg <= w;
    instr <= '{1'b1, op, s, m, off};
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
  endtask
  task automatic stq(input logic [15:0] a, input logic [7:0] d);
    chk("store request", {8'h03, d, a}, {6'h00, memReq.valid, memReq.write, memReq.data, memReq.addr});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(4'h4, 8'hff);
    rd(4'h6, 8'h04);
    rd(4'h9, 8'h00);
    setp(1'b1, 16'hffff);
    ex(isc_pkg::ISC_OP_STORE_IND, 1'b1, 2'h0, 6'h00, 8'h3c);
    stq(16'h0000, 8'h3c);
    rdp(1'b1, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      setp(1'b0, 16'h0100);
      ex(isc_pkg::ISC_OP_STORE_IND, 1'b0, m[1:0], 6'h00, {6'h00, m[1:0]});
      ea = m == 0 ? 16'h0101 : m == 1 ? 16'h00ff : 16'h0100;
      np = m[0] ? 16'h00ff : 16'h0101;
      stq(ea, {6'h00, m[1:0]});
      rdp(1'b0, np);
    end
    setp(1'b0, 16'h0000);
    ex(isc_pkg::ISC_OP_STORE_IND, 1'b0, 2'h3, 6'h00, 8'h55);
    stq(16'h0000, 8'h55);
    rdp(1'b0, 16'hffff);
    setp(1'b0, 16'h0100);
    ex(isc_pkg::ISC_OP_STORE_REL, 1'b0, 2'h2, 6'h20, 8'h61);
    stq(16'h00e0, 8'h61);
    ex(isc_pkg::ISC_OP_STORE_REL, 1'b0, 2'h0, 6'h1f, 8'h62);
    stq(16'h011f, 8'h62);
    rdp(1'b0, 16'h0100);
    chk("memory", 8'h62, fm.mem[16'h011f]);
    @(posedge clk);
    fileAcc <= '{1'b1, 1'b1, 7'h01, 8'h77};
    @(posedge clk);
    fileAcc.valid <= 1'b0;
    #1 stq(16'h0000, 8'h77);
    @(posedge clk);
    fileAcc <= '{1'b1, 1'b0, 7'h00, 8'h00};
    @(posedge clk);
    fileAcc.valid <= 1'b0;
    #1 chk("window read", {2'h2, 16'h0100}, {memReq.valid, memReq.write, memReq.addr});
    chk("window memory", 8'h77, fm.mem[16'h0000]);
    ex(isc_pkg::ISC_OP_OPTION, 1'b0, 2'h0, 6'h00, 8'h4f);
    chk("option", 8'h4f, optionCfg);
    ex(isc_pkg::ISC_OP_NOP, 1'b0, 2'h0, 6'h00, 8'h99);
    chk("no-op", 16'h4f00, {optionCfg, 7'h00, memReq.valid});
    ex(isc_pkg::ISC_OP_RETIRQ, 1'b0, 2'h0, 6'h00, 8'h00);
    chk("return", {4'hd, 15'h0123}, {stackPop, pcLoad, instrReady, irqControl[7], pcValue});
    wr(4'h5, 8'h00);
    ex(isc_pkg::ISC_OP_RETIRQ, 1'b0, 2'h0, 6'h00, 8'h00);
    chk("return", {4'hd, 15'h7abc}, {stackPop, pcLoad, instrReady, irqControl[7], pcValue});
    setp(1'b0, 16'h1234);
    ex(isc_pkg::ISC_OP_SWRESET, 1'b0, 2'h0, 6'h00, 8'h00);
    chk("soft reset", {1'b1, 8'hff, 8'h00}, {deviceResetReq, optionCfg, irqControl});
    rd(4'h6, 8'h00);
    rdp(1'b0, 16'h0000);
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h04);
    wrap_up();
  end
endmodule
`default_nettype wire
